// *** include/dief_pkg.sv ***
// constants of the dac input elastic buffer
package dief_pkg;
    localparam int SAMPLE_W = 16;
    localparam int WORD_W = 2 * SAMPLE_W + 1;
    localparam int PTR_W = 2;
    localparam int ELASTIC_DEPTH = 4;
    localparam int OUT_FIFO_DEPTH = 16;
    localparam int MSB_POS = 15;
    localparam int STROBE_POS = 2 * SAMPLE_W;
    localparam logic [PTR_W-1:0] WR_PTR_INIT = 2'h0;
    localparam logic [PTR_W-1:0] RD_PTR_INIT = 2'h2;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_BASE = 4'h2;
    localparam logic [2:0] SYNC_TXEN = 3'h0;
    localparam logic [2:0] SYNC_STROBE = 3'h1;
    localparam logic [2:0] SYNC_MARKER = 3'h2;
    localparam logic [2:0] SYNC_B15 = 3'h3;
    localparam logic [2:0] SYNC_A15_ONCE = 3'h4;
    localparam logic [2:0] SYNC_WRITE_A = 3'h5;
    localparam logic [2:0] SYNC_OFF = 3'h6;
    localparam logic [2:0] SYNC_WRITE_B = 3'h7;
endpackage : dief_pkg

// *** verilog/dief_fifo.sv ***
// parameterised valid/ready fifo between the elastic buffer and the dac side
`timescale 1ns/1ps
module dief_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrIdx, rdIdx, next_wrIdx, next_rdIdx;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdIdx];

    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        next_wrIdx = push ? AW'(wrIdx + 1'b1) : wrIdx;
        next_rdIdx = pop ? AW'(rdIdx + 1'b1) : rdIdx;
        next_count = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrIdx <= '0;
            rdIdx <= '0;
            count <= '0;
        end else begin
            wrIdx <= next_wrIdx;
            rdIdx <= next_rdIdx;
            count <= next_count;
        end
    end

    // storage needs no reset; occupancy guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrIdx] <= inData;
        end
    end
endmodule : dief_fifo

// *** verilog/dief_input_fifo.sv ***
// dac input elastic buffer: pin capture, four-slot pointer buffer and output stage
// Behaviour
// - optional buffer captures both ports and strobe
// - bypass bit routes samples around the buffer
// - four-entry register file, write and read pointers
// - init sets write slot 0, read slot 2
// - sync field picks enable, strobe, marker, B15
// - A15 one-shot, write-now codes, code 110 off
// - source registered then rising edge initializes
// - write pointer advances every own clock, read pointer holds while the fifo is full, no correction
// - half-rate muxes both ports onto channel A
// - single mode divides clock, edge by invert
// - dual mode with buffer crosses, needs initialization
// - dual mode: invert bit selects buffer use
`timescale 1ns/1ps
module dief_input_fifo (
    input wire logic clk,
    input wire logic srst,
    input wire logic [dief_pkg::SAMPLE_W-1:0] samplePortA,
    input wire logic [dief_pkg::SAMPLE_W-1:0] samplePortB,
    input wire logic phaseStrobe,
    input wire logic txEnable,
    input wire logic channelMarker,
    input wire logic inputRateClock,
    input wire logic bufferBypass,
    input wire logic dualClk,
    input wire logic latchInvert,
    input wire logic halfRate,
    input wire logic [1:0] interpSel,
    input wire logic [2:0] syncSource,
    input wire logic serialWrite,
    input wire logic dacReady,
    output logic rateClockOut,
    output logic [dief_pkg::SAMPLE_W-1:0] dacChanA,
    output logic [dief_pkg::SAMPLE_W-1:0] dacChanB,
    output logic dacStrobe,
    output logic dacValid,
    output logic bufferInitDone
);
    import dief_pkg::*;

    // pin inputs: three stages, a change is taken once stages two and three agree
    logic [WORD_W+2:0] pinS1, pinS2, pinS3, pinFilt, next_pinFilt;
    logic [DIV_W-1:0] divCnt, next_divCnt;
    // one bit wider than the counter so the longest period, sixteen, still fits
    logic [DIV_W:0] divPeriod;
    logic rdTick, wrTick, clkPrev, next_clkPrev;
    logic [WORD_W-1:0] latchWord;
    logic useBuffer;
    logic [WORD_W-1:0] regFile [ELASTIC_DEPTH];
    logic [PTR_W-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic syncLevel, syncPrev, next_syncLevel, next_syncPrev, a15Armed, next_a15Armed;
    logic initPulse, edgeSeen;
    logic pushValid, pushReady;
    logic [WORD_W-1:0] pushWord;
    logic fifoValid, fifoPop;
    logic [WORD_W-1:0] fifoWord;
    logic oddPhase, next_oddPhase, next_dacValid, next_rateClockOut, next_initDone;
    logic [SAMPLE_W-1:0] next_chanA, next_chanB;
    logic next_strobe;

    function automatic logic [2:0] pinBit(input logic [2:0] sel);
        // fixed positions of the control pins above the data word
        return sel;
    endfunction : pinBit

    always_comb begin
        // a bit follows the pin only when the last two stages agree
        next_pinFilt = (pinS2 & pinS3) | (pinFilt & (pinS2 ^ pinS3));
        latchWord = pinFilt[WORD_W-1:0];
        divPeriod = (DIV_W+1)'({1'b0, DIV_BASE} << interpSel);
        next_divCnt = ({1'b0, divCnt} == (DIV_W+1)'(divPeriod - 1'b1)) ?
            '0 : DIV_W'(divCnt + 1'b1);
        rdTick = (divCnt == '0);
        next_rateClockOut = ({1'b0, next_divCnt} < (divPeriod >> 1));
        next_clkPrev = pinFilt[WORD_W + 2];
        if (dualClk) begin
            wrTick = pinFilt[WORD_W + 2] && !clkPrev;
        end else if (latchInvert) begin
            wrTick = ({1'b0, divCnt} == (divPeriod >> 1));
        end else begin
            wrTick = rdTick;
        end
        useBuffer = !bufferBypass && (!dualClk || latchInvert);
    end

    always_ff @(posedge clk) begin
        pinS1 <= {inputRateClock, channelMarker, txEnable, phaseStrobe, samplePortB, samplePortA};
        pinS2 <= pinS1;
        pinS3 <= pinS2;
        if (srst) begin
            pinFilt <= '0;
            divCnt <= '0;
            clkPrev <= 1'b0;
            rateClockOut <= 1'b0;
        end else begin
            pinFilt <= next_pinFilt;
            divCnt <= next_divCnt;
            clkPrev <= next_clkPrev;
            rateClockOut <= next_rateClockOut;
        end
    end

    // sync source selection and edge detection on the write-side tick
    always_comb begin
        next_syncLevel = syncLevel;
        next_syncPrev = syncPrev;
        next_a15Armed = a15Armed;
        case (syncSource)
            SYNC_TXEN: next_syncLevel = pinFilt[WORD_W + pinBit(3'h1) - 1];
            SYNC_STROBE: next_syncLevel = pinFilt[STROBE_POS];
            SYNC_MARKER: next_syncLevel = pinFilt[WORD_W + pinBit(3'h2) - 1];
            SYNC_B15: next_syncLevel = pinFilt[SAMPLE_W + MSB_POS];
            SYNC_A15_ONCE: next_syncLevel = pinFilt[MSB_POS];
            default: next_syncLevel = 1'b0;
        endcase
        if (!wrTick) begin
            next_syncLevel = syncLevel;
        end else begin
            next_syncPrev = syncLevel;
        end
        edgeSeen = wrTick && syncLevel && !syncPrev;
        initPulse = 1'b0;
        case (syncSource)
            SYNC_A15_ONCE: begin
                initPulse = edgeSeen && a15Armed;
                if (initPulse) begin
                    next_a15Armed = 1'b0;
                end
            end
            SYNC_WRITE_A, SYNC_WRITE_B: initPulse = serialWrite;
            SYNC_OFF: initPulse = 1'b0;
            default: initPulse = edgeSeen;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            syncLevel <= 1'b0;
            syncPrev <= 1'b0;
            a15Armed <= 1'b1;
        end else begin
            syncLevel <= next_syncLevel;
            syncPrev <= next_syncPrev;
            a15Armed <= next_a15Armed;
        end
    end

    // elastic pointers; the read side stalls only when the downstream fifo is full
    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_initDone = bufferInitDone;
        if (initPulse) begin
            next_wrPtr = WR_PTR_INIT;
            next_rdPtr = RD_PTR_INIT;
            next_initDone = 1'b1;
        end else begin
            if (useBuffer && wrTick) begin
                next_wrPtr = PTR_W'(wrPtr + 1'b1);
            end
            if (useBuffer && rdTick && pushReady) begin
                next_rdPtr = PTR_W'(rdPtr + 1'b1);
            end
        end
        if (useBuffer) begin
            pushValid = rdTick;
            pushWord = regFile[rdPtr];
        end else begin
            pushValid = wrTick;
            pushWord = latchWord;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr <= WR_PTR_INIT;
            rdPtr <= RD_PTR_INIT;
            bufferInitDone <= 1'b0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            bufferInitDone <= next_initDone;
        end
    end

    // overrun is silent: a write may land on the slot being read
    always_ff @(posedge clk) begin
        if (useBuffer && wrTick) begin
            regFile[wrPtr] <= latchWord;
        end
    end

    dief_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(OUT_FIFO_DEPTH)
    ) u_out_fifo (
        .clk(clk),
        .srst(srst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoWord)
    );

    // output stage; half-rate sends port A then port B on channel A
    always_comb begin
        next_chanA = dacChanA;
        next_chanB = dacChanB;
        next_strobe = dacStrobe;
        next_dacValid = dacValid && !dacReady;
        next_oddPhase = oddPhase;
        fifoPop = 1'b0;
        if (!dacValid || dacReady) begin
            if (halfRate && oddPhase) begin
                next_chanA = fifoWord[SAMPLE_W +: SAMPLE_W];
                next_chanB = '0;
                next_strobe = 1'b0;
                next_dacValid = 1'b1;
                next_oddPhase = 1'b0;
                fifoPop = 1'b1;
            end else if (fifoValid) begin
                next_chanA = fifoWord[SAMPLE_W-1:0];
                next_chanB = halfRate ? '0 : fifoWord[SAMPLE_W +: SAMPLE_W];
                next_strobe = fifoWord[STROBE_POS];
                next_dacValid = 1'b1;
                next_oddPhase = halfRate;
                fifoPop = !halfRate;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dacChanA <= '0;
            dacChanB <= '0;
            dacStrobe <= 1'b0;
            dacValid <= 1'b0;
            oddPhase <= 1'b0;
        end else begin
            dacChanA <= next_chanA;
            dacChanB <= next_chanB;
            dacStrobe <= next_strobe;
            dacValid <= next_dacValid;
            oddPhase <= next_oddPhase;
        end
    end

    property p_init_ptrs;
        @(posedge clk) disable iff (srst) initPulse |=> (wrPtr == 2'h0) && (rdPtr == 2'h2);
    endproperty
    a_init_ptrs: assert property (p_init_ptrs) else $error("init pointers wrong");
    property p_wr_adv;
        @(posedge clk) disable iff (srst)
            (useBuffer && wrTick && !initPulse) |=> wrPtr == 2'($past(wrPtr) + 2'h1);
    endproperty
    a_wr_adv: assert property (p_wr_adv) else $error("write pointer stuck");
    property p_rd_adv;
        @(posedge clk) disable iff (srst)
            (useBuffer && rdTick && pushReady && !initPulse) |=> rdPtr == 2'($past(rdPtr) + 2'h1);
    endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("read pointer stuck");
    property p_bypass_hold;
        @(posedge clk) disable iff (srst)
            (!useBuffer && !initPulse) |=> $stable(wrPtr) && $stable(rdPtr);
    endproperty
    a_bypass_hold: assert property (p_bypass_hold) else $error("bypass moved pointers");
    property p_sync_off;
        @(posedge clk) disable iff (srst) (syncSource == 3'h6) |-> !initPulse;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("disabled source initialized");
    property p_sync_write;
        @(posedge clk) disable iff (srst)
            (serialWrite && (syncSource == 3'h5 || syncSource == 3'h7)) |-> initPulse;
    endproperty
    a_sync_write: assert property (p_sync_write) else $error("write did not initialize");
    property p_one_shot;
        @(posedge clk) disable iff (srst) (syncSource == 3'h4 && !a15Armed) |-> !initPulse;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot fired twice");
    property p_edge_init;
        @(posedge clk) disable iff (srst)
            (syncSource == 3'h1 && wrTick && syncLevel && !syncPrev) |-> initPulse ##1 bufferInitDone;
    endproperty
    a_edge_init: assert property (p_edge_init) else $error("rising edge missed");
    property p_half_rate;
        @(posedge clk) disable iff (srst) (halfRate && $past(halfRate) && dacValid) |-> dacChanB == '0;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("channel B used in half rate");
endmodule : dief_input_fifo

// *** testbench/dief_source_model.sv ***
// data source model that drives the sample pins and its own input-rate clock
`timescale 1ns/1ps
module dief_source_model (
    input wire logic rateClockOut,
    input wire logic dualClk,
    input wire logic [dief_pkg::WORD_W-1:0] srcWord,
    output logic [dief_pkg::SAMPLE_W-1:0] samplePortA,
    output logic [dief_pkg::SAMPLE_W-1:0] samplePortB,
    output logic phaseStrobe,
    output logic inputRateClock
);
    import dief_pkg::*;
    logic srcClk;
    // own clock only in dual mode; its period is not a multiple of clk, so phase drifts
    initial begin
        {phaseStrobe, samplePortB, samplePortA} = '0;
        inputRateClock = 1'b0;
        forever begin
            #70;
            inputRateClock = dualClk ? ~inputRateClock : 1'b0;
        end
    end
    assign srcClk = dualClk ? inputRateClock : rateClockOut;
    // one word per rising source clock edge, never faster
    always @(posedge srcClk) begin
        {phaseStrobe, samplePortB, samplePortA} <= srcWord;
    end
endmodule : dief_source_model

// *** testbench/dief_input_fifo_tb_top.sv ***
// self-checking bench of the dac input elastic buffer
`timescale 1ns/1ps
module dief_input_fifo_tb_top;
    import dief_pkg::*;
    logic clk, srst, txEnable, channelMarker, inputRateClock, phaseStrobe;
    logic bufferBypass, dualClk, latchInvert, halfRate, serialWrite, dacReady;
    logic rateClockOut, dacStrobe, dacValid, bufferInitDone, sawA, sawB;
    logic [1:0] interpSel;
    logic [2:0] syncSource;
    logic [SAMPLE_W-1:0] samplePortA, samplePortB, dacChanA, dacChanB;
    logic [WORD_W-1:0] srcWord, held;
    logic [15:0] seed;
    logic [2:0] modes [6] = '{3'h4, 3'h0, 3'h3, 3'h5, 3'h1, 3'h6};
    int err_total, checks;

    dief_source_model src_u (.rateClockOut(rateClockOut), .dualClk(dualClk),
        .srcWord(srcWord), .samplePortA(samplePortA), .samplePortB(samplePortB),
        .phaseStrobe(phaseStrobe), .inputRateClock(inputRateClock));
    dief_input_fifo dut_u (.clk(clk), .srst(srst), .samplePortA(samplePortA),
        .samplePortB(samplePortB), .phaseStrobe(phaseStrobe), .txEnable(txEnable),
        .channelMarker(channelMarker), .inputRateClock(inputRateClock),
        .bufferBypass(bufferBypass), .dualClk(dualClk), .latchInvert(latchInvert),
        .halfRate(halfRate), .interpSel(interpSel), .syncSource(syncSource),
        .serialWrite(serialWrite), .dacReady(dacReady), .rateClockOut(rateClockOut),
        .dacChanA(dacChanA), .dacChanB(dacChanB), .dacStrobe(dacStrobe),
        .dacValid(dacValid), .bufferInitDone(bufferInitDone));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic give_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word(WORD_W'(got), WORD_W'(exp));
    endtask : cmp_flag

    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask : ticks

    function automatic int rate_period(input logic [1:0] sel);
        return 2 << sel;
    endfunction : rate_period

    // a stuck rate clock uses up the bounds, counts as a mismatch and ends the run
    task automatic chk_rate(input int per);
        int n, hi, lo;
        n = 0;
        hi = 0;
        lo = 0;
        while (rateClockOut !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        while (rateClockOut !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        while (rateClockOut === 1'b1 && hi < 40) begin
            @(negedge clk);
            hi++;
        end
        while (rateClockOut === 1'b0 && lo < 40) begin
            @(negedge clk);
            lo++;
        end
        cmp_word(WORD_W'(hi), WORD_W'(per / 2));
        cmp_word(WORD_W'(hi + lo), WORD_W'(per));
        if (hi + lo >= 40) begin
            give_verdict();
        end
    endtask : chk_rate

    task automatic wait_valid();
        int n;
        n = 0;
        while (dacValid !== 1'b1) begin
            n++;
            if (n > 400) begin
                cmp_flag(dacValid, 1'b1);
                give_verdict();
            end
            @(negedge clk);
        end
    endtask : wait_valid

    // reset length covers the pin synchronisers as well
    task automatic restart(input logic [2:0] code);
        syncSource = code;
        srst = 1'b1;
        ticks(16);
        srst = 1'b0;
        ticks(1);
    endtask : restart

    task automatic init_now();
        serialWrite = 1'b1;
        ticks(1);
        serialWrite = 1'b0;
        ticks(40);
    endtask : init_now

    task automatic new_word();
        seed = lfsr(seed);
        srcWord[15:0] = seed;
        seed = lfsr(seed);
        srcWord[31:16] = seed;
        srcWord[32] = seed[3];
    endtask : new_word

    initial begin
        {srst, txEnable, channelMarker, dualClk, latchInvert, halfRate, serialWrite} = '0;
        {bufferBypass, dacReady} = 2'h3;
        interpSel = 2'h0;
        syncSource = SYNC_OFF;
        srcWord = '0;
        held = '0;
        seed = 16'h003E;
        err_total = 0;
        checks = 0;
        // every sync code: only code 110 must leave the pointers uninitialised
        for (int c = 0; c < 8; c++) begin
            restart(3'(c));
            cmp_flag(bufferInitDone, 1'b0);
            cmp_flag(dacValid, 1'b0);
            init_now();
            cmp_flag(bufferInitDone, c == 5 || c == 7);
            {txEnable, channelMarker} = 2'h3;
            srcWord = '1;
            ticks(60);
            cmp_flag(bufferInitDone, c != 6);
            {txEnable, channelMarker} = 2'h0;
            srcWord = '0;
            // let the source settle low so no stale level looks like an edge after reset
            ticks(8);
        end
        // every clock mode, buffered or not, each divider setting then random ones
        for (int m = 0; m < 6; m++) begin
            {bufferBypass, dualClk, latchInvert} = modes[m];
            seed = lfsr(seed);
            // the first four modes walk every divider setting, the rest draw one
            interpSel = (m < 4) ? 2'(m) : seed[1:0];
            restart(SYNC_WRITE_A);
            init_now();
            chk_rate(rate_period(interpSel));
            repeat (3) begin
                new_word();
                ticks(150);
                wait_valid();
                cmp_word({dacStrobe, dacChanB, dacChanA}, srcWord);
            end
        end
        {bufferBypass, dualClk, latchInvert, halfRate} = 4'h9;
        interpSel = 2'h1;
        restart(SYNC_OFF);
        new_word();
        srcWord[31:16] = ~srcWord[15:0];
        ticks(60);
        {sawA, sawB} = 2'h0;
        repeat (40) begin
            @(negedge clk);
            if (dacValid === 1'b1) begin
                sawA |= dacChanA === srcWord[15:0];
                sawB |= dacChanA === srcWord[31:16];
                cmp_word(WORD_W'(dacChanB), '0);
            end
        end
        cmp_flag(sawA & sawB, 1'b1);
        // stall downstream until the 16-word fifo refuses, then drain it
        halfRate = 1'b0;
        interpSel = 2'h0;
        restart(SYNC_OFF);
        new_word();
        held = srcWord;
        ticks(60);
        dacReady = 1'b0;
        ticks(10);
        cmp_flag(dacValid, 1'b1);
        new_word();
        ticks(200);
        cmp_word({dacStrobe, dacChanB, dacChanA}, held);
        dacReady = 1'b1;
        ticks(200);
        wait_valid();
        cmp_word({dacStrobe, dacChanB, dacChanA}, srcWord);
        give_verdict();
    end
endmodule : dief_input_fifo_tb_top
